// *** verilog/rcc_pkg.sv ***
package rcc_pkg;
  localparam logic [31:0] RCC_MAIN_ADDR = 32'hFFFC1400;
  localparam logic [31:0] RCC_PF_ADDR = 32'hFFFC1408;
  localparam logic [31:0] RCC_MAIN_RST = 32'h00000001;
  localparam logic [31:0] RCC_PF_RST = 32'h000000F5;
  // storable bits; flush bits and reserved bits are never held
  localparam logic [31:0] RCC_MAIN_MASK = 32'h00000001;
  localparam logic [31:0] RCC_PF_MASK = 32'h000000F5;
  localparam logic [2:0] RCC_HSIZE_WORD = 3'h2;

  localparam int unsigned RCC_GEN_BIT = 0;
  localparam int unsigned RCC_DFL_BIT = 1;
  localparam int unsigned RCC_IFL_BIT = 2;
  localparam int unsigned RCC_WFL_BIT = 3;
  localparam int unsigned RCC_DCE_BIT = 0;
  localparam int unsigned RCC_MCE_BIT = 2;
  localparam int unsigned RCC_PCE_BIT = 4;
  localparam int unsigned RCC_SEQ_BIT = 5;
  localparam int unsigned RCC_UNC_BIT = 6;
  localparam int unsigned RCC_CND_BIT = 7;

  localparam int unsigned RCC_TAG_HI = 22;
  localparam int unsigned RCC_DTAG_W = 19;
  localparam int unsigned RCC_PTAG_W = 18;
  localparam int unsigned RCC_SET_BIT = 4;
  localparam int unsigned RCC_WAYS = 4;
  localparam logic [31:0] RCC_LINE_BYTES = 32'h00000010;

  // instruction encodings seen by the branch predictor
  localparam logic [7:0] RCC_OP_BT = 8'h89;
  localparam logic [7:0] RCC_OP_BF = 8'h8B;
  localparam logic [7:0] RCC_OP_BTD = 8'h8D;
  localparam logic [7:0] RCC_OP_BFD = 8'h8F;
  localparam logic [3:0] RCC_OP_BRA = 4'hA;
  localparam logic [3:0] RCC_OP_BSR = 4'hB;
  localparam logic [3:0] RCC_OP_REGGRP = 4'h4;
  localparam logic [7:0] RCC_OP_JMP = 8'h2B;
  localparam logic [7:0] RCC_OP_JSR = 8'h0B;
  localparam logic [7:0] RCC_OP_JSRN = 8'h4B;
  localparam logic [3:0] RCC_OP_MOVI = 4'h0;

  typedef logic [127:0] rcc_line_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } rcc_rdreq_s;

  typedef enum logic [1:0] {
    RCC_IDLE = 2'b01,
    RCC_FILL = 2'b10
  } rcc_state_e;

  typedef enum logic [2:0] {
    RCC_K_DATA = 3'b001,
    RCC_K_INSTR = 3'b010,
    RCC_K_PREF = 3'b100
  } rcc_kind_e;
endpackage

// *** verilog/rcc_assoc.sv ***
`timescale 1ns/100ps
`default_nettype none
module rcc_assoc #(
  parameter int unsigned TW = 19
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [TW-1:0] lk_tag,
  input wire logic touch,
  input wire logic fill,
  input wire logic [TW-1:0] fill_tag,
  input wire rcc_pkg::rcc_line_t fill_line,
  output logic hit,
  output rcc_pkg::rcc_line_t hit_line
);
  import rcc_pkg::*;

  logic [RCC_WAYS-1:0] valid_r;
  logic [TW-1:0] tag_r [RCC_WAYS];
  rcc_line_t line_r [RCC_WAYS];
  logic [1:0] age_r [RCC_WAYS];
  logic [1:0] hit_way, victim, use_way;

  always_comb begin
    hit = 1'b0;
    hit_way = 2'd0;
    victim = 2'd0;
    for (int w = 0; w < RCC_WAYS; w++) begin
      if (valid_r[w] && tag_r[w] == lk_tag) begin
        hit = 1'b1;
        hit_way = w[1:0];
      end
      if (age_r[w] == 2'd3) victim = w[1:0];
    end
    hit_line = line_r[hit_way];
    use_way = fill ? victim : hit_way;
  end

  // ages form a permutation 0..3; the oldest line is refilled first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < RCC_WAYS; w++) age_r[w] <= w[1:0];
    end else if (fill || (touch && hit)) begin
      for (int w = 0; w < RCC_WAYS; w++) begin
        if (w[1:0] == use_way) age_r[w] <= 2'd0;
        else if (age_r[w] < age_r[use_way]) age_r[w] <= age_r[w] + 2'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) valid_r <= '0;
    else if (flush) valid_r <= '0;
    else if (fill) valid_r[victim] <= 1'b1;
  end

  // data and tags are not reset; invalid lines never hit
  always_ff @(posedge clk) begin
    if (fill) begin
      tag_r[victim] <= fill_tag;
      line_r[victim] <= fill_line;
    end
  end
endmodule
`default_nettype wire

// *** verilog/rcc_cache.sv ***
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - whole flush bit clears all valid bits
// - instruction flush clears prefetch and miss caches
// - data flush clears only data cache
// - global enable bit, resets to one
// - per-cache enables, register resets to F5
// - conditional, unconditional, sequential prefetch enables
// - second register at its own address
// - reserved bits read zero, write zero
// - data lookup compares bits 22..4, four tags
// - hit needs tag match and valid bit
// - address bits 3..2 pick the returned word
// - data miss fills LRU line, forwards word
// - prefetch lookup: bit 4 picks set, tag 22..5
// - miss cache fills when both instruction caches miss
// - prefetch fills LRU line of its set
// - prefetch next sequential line ahead
// - prefetch predicted conditional branch destination
// - prefetch relative branch and call targets
// - register jumps prefetched only when value known
// - eight-line 4-way plus two 4-line caches
// - 16-byte lines of four words
// - reset or standby clears all valid bits
// - address bits 31..23 never compared in cache lookups
module rcc_cache (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic standby,
  input wire rcc_pkg::rcc_rdreq_s ifetch,
  output logic if_ack,
  output logic [31:0] if_data,
  input wire rcc_pkg::rcc_rdreq_s dread,
  output logic dr_ack,
  output logic [31:0] dr_data,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ready,
  input wire rcc_pkg::rcc_line_t mem_line
);
  import rcc_pkg::*;

  function automatic logic [31:0] rcc_word(rcc_line_t l, logic [31:0] a);
    logic [1:0] sel;
    sel = a[3:2];
    return l[32*sel +: 32];
  endfunction

  function automatic logic [32:0] rcc_br_target(logic [15:0] op,
      logic [31:0] pc, logic cnd, logic unc);
    logic [31:0] d8;
    logic [31:0] d12;
    logic [32:0] r;
    d8 = {{23{op[7]}}, op[7:0], 1'b0};
    d12 = {{19{op[11]}}, op[11:0], 1'b0};
    r = '0;
    if (cnd && (op[15:8] == RCC_OP_BT || op[15:8] == RCC_OP_BF ||
        op[15:8] == RCC_OP_BTD || op[15:8] == RCC_OP_BFD))
      r = {1'b1, pc + 32'h4 + d8};
    else if (unc && (op[15:12] == RCC_OP_BRA || op[15:12] == RCC_OP_BSR))
      r = {1'b1, pc + 32'h4 + d12};
    return r;
  endfunction

  // register interface
  logic ph_wr_r, ph_main_r, ph_pf_r;
  logic [31:0] main_r, main_nxt, pf_r, pf_nxt, hrdata_r;
  logic acc, wr_main, wr_pf;
  logic fl_all, fl_i, fl_d;
  logic g_en, dc_en, mc_en, pc_en, seq_en, unc_en, cnd_en;

  assign acc = hsel && htrans[1] && hready;
  assign wr_main = ph_wr_r && ph_main_r;
  assign wr_pf = ph_wr_r && ph_pf_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
      ph_main_r <= 1'b0;
      ph_pf_r <= 1'b0;
    end else begin
      // narrower writes are dropped so a stray byte store cannot flush
      ph_wr_r <= acc && hwrite && hsize == RCC_HSIZE_WORD;
      ph_main_r <= acc && haddr == RCC_MAIN_ADDR;
      ph_pf_r <= acc && haddr == RCC_PF_ADDR;
    end
  end

  always_comb begin
    main_nxt = main_r;
    pf_nxt = pf_r;
    if (standby) begin
      main_nxt = RCC_MAIN_RST;
      pf_nxt = RCC_PF_RST;
    end else begin
      if (wr_main) main_nxt = hwdata & RCC_MAIN_MASK;
      if (wr_pf) pf_nxt = hwdata & RCC_PF_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_r <= RCC_MAIN_RST;
      pf_r <= RCC_PF_RST;
    end else begin
      main_r <= main_nxt;
      pf_r <= pf_nxt;
    end
  end

  // read data is taken from the next-state values, so a read right
  // behind a write returns the freshly written value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_r <= '0;
    else if (acc && !hwrite) begin
      if (haddr == RCC_MAIN_ADDR) hrdata_r <= main_nxt;
      else if (haddr == RCC_PF_ADDR) hrdata_r <= pf_nxt;
      else hrdata_r <= '0;
    end
  end

  assign fl_all = standby || (wr_main && hwdata[RCC_WFL_BIT]);
  assign fl_i = fl_all || (wr_main && hwdata[RCC_IFL_BIT]);
  assign fl_d = fl_all || (wr_main && hwdata[RCC_DFL_BIT]);

  assign g_en = main_r[RCC_GEN_BIT];
  assign dc_en = g_en && pf_r[RCC_DCE_BIT];
  assign mc_en = g_en && pf_r[RCC_MCE_BIT];
  assign pc_en = g_en && pf_r[RCC_PCE_BIT];
  assign seq_en = pf_r[RCC_SEQ_BIT];
  assign unc_en = pf_r[RCC_UNC_BIT];
  assign cnd_en = pf_r[RCC_CND_BIT];

  // fill engine
  rcc_state_e state_r;
  rcc_kind_e kind_r;
  logic [31:0] fill_addr_r;
  logic if_ack_r, dr_ack_r;
  logic [31:0] if_data_r, dr_data_r;
  logic pf_pend_r;
  logic [31:0] pf_addr_r;
  logic kn_vld_r;
  logic [3:0] kn_reg_r;
  logic [31:0] kn_val_r;

  logic i_srv, d_srv, done;
  logic [31:0] i_addr;
  logic d_hit, m_hit, e_hit, o_hit, p_hit, i_hit;
  rcc_line_t d_line, m_line, e_line, o_line;
  logic d_fill, m_fill, e_fill, o_fill;

  assign i_srv = ifetch.req && !if_ack_r;
  assign d_srv = dread.req && !dr_ack_r;
  assign done = state_r == RCC_FILL && mem_ready;
  assign i_addr = i_srv ? ifetch.addr : pf_addr_r;
  assign mem_req = state_r == RCC_FILL;
  assign mem_addr = fill_addr_r;
  assign if_ack = if_ack_r;
  assign if_data = if_data_r;
  assign dr_ack = dr_ack_r;
  assign dr_data = dr_data_r;

  assign d_fill = done && kind_r == RCC_K_DATA && dc_en;
  assign m_fill = done && kind_r == RCC_K_INSTR && mc_en;
  assign e_fill = done && kind_r == RCC_K_PREF && pc_en &&
                  !fill_addr_r[RCC_SET_BIT];
  assign o_fill = done && kind_r == RCC_K_PREF && pc_en &&
                  fill_addr_r[RCC_SET_BIT];

  rcc_assoc #(.TW(RCC_DTAG_W)) u_dcache (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fl_d),
    .lk_tag(dread.addr[RCC_TAG_HI:4]),
    .touch(d_srv && dc_en),
    .fill(d_fill),
    .fill_tag(fill_addr_r[RCC_TAG_HI:4]),
    .fill_line(mem_line),
    .hit(d_hit),
    .hit_line(d_line)
  );

  rcc_assoc #(.TW(RCC_DTAG_W)) u_mcache (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fl_i),
    .lk_tag(i_addr[RCC_TAG_HI:4]),
    .touch(i_srv && mc_en),
    .fill(m_fill),
    .fill_tag(fill_addr_r[RCC_TAG_HI:4]),
    .fill_line(mem_line),
    .hit(m_hit),
    .hit_line(m_line)
  );

  rcc_assoc #(.TW(RCC_PTAG_W)) u_pf_even (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fl_i),
    .lk_tag(i_addr[RCC_TAG_HI:5]),
    .touch(i_srv && pc_en && !i_addr[RCC_SET_BIT]),
    .fill(e_fill),
    .fill_tag(fill_addr_r[RCC_TAG_HI:5]),
    .fill_line(mem_line),
    .hit(e_hit),
    .hit_line(e_line)
  );

  rcc_assoc #(.TW(RCC_PTAG_W)) u_pf_odd (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fl_i),
    .lk_tag(i_addr[RCC_TAG_HI:5]),
    .touch(i_srv && pc_en && i_addr[RCC_SET_BIT]),
    .fill(o_fill),
    .fill_tag(fill_addr_r[RCC_TAG_HI:5]),
    .fill_line(mem_line),
    .hit(o_hit),
    .hit_line(o_line)
  );

  assign p_hit = pc_en && (i_addr[RCC_SET_BIT] ? o_hit : e_hit);
  assign i_hit = p_hit || (mc_en && m_hit);

  // the word handed to the core this cycle, if any
  logic i_deliv;
  logic [31:0] i_word;
  rcc_line_t i_line;

  always_comb begin
    i_line = p_hit ? (i_addr[RCC_SET_BIT] ? o_line : e_line) : m_line;
    i_deliv = 1'b0;
    i_word = rcc_word(mem_line, ifetch.addr);
    if (i_srv && i_hit) begin
      i_deliv = 1'b1;
      i_word = rcc_word(i_line, ifetch.addr);
    end else if (done && kind_r == RCC_K_INSTR) begin
      i_deliv = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      if_ack_r <= 1'b0;
      if_data_r <= '0;
    end else begin
      if_ack_r <= i_deliv;
      if (i_deliv) if_data_r <= i_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_ack_r <= 1'b0;
      dr_data_r <= '0;
    end else begin
      dr_ack_r <= (d_srv && dc_en && d_hit) ||
                  (done && kind_r == RCC_K_DATA);
      if (d_srv && dc_en && d_hit)
        dr_data_r <= rcc_word(d_line, dread.addr);
      else if (done && kind_r == RCC_K_DATA)
        dr_data_r <= rcc_word(mem_line, dread.addr);
    end
  end

  // demand data first, then demand instruction, then prefetch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= RCC_IDLE;
      kind_r <= RCC_K_DATA;
      fill_addr_r <= '0;
    end else begin
      unique case (state_r)
        RCC_IDLE: begin
          if (d_srv && !(dc_en && d_hit)) begin
            state_r <= RCC_FILL;
            kind_r <= RCC_K_DATA;
            fill_addr_r <= {dread.addr[31:4], 4'h0};
          end else if (i_srv && !i_hit) begin
            state_r <= RCC_FILL;
            kind_r <= RCC_K_INSTR;
            fill_addr_r <= {ifetch.addr[31:4], 4'h0};
          end else if (!i_srv && pf_pend_r && pc_en && !i_hit) begin
            state_r <= RCC_FILL;
            kind_r <= RCC_K_PREF;
            fill_addr_r <= {pf_addr_r[31:4], 4'h0};
          end
        end
        RCC_FILL: begin
          if (mem_ready) state_r <= RCC_IDLE;
        end
      endcase
    end
  end

  // branch prediction on each word handed to the core
  logic [15:0] op_hi, op_lo;
  logic [31:0] pc_hi;
  logic [32:0] t_hi, t_lo;
  logic ind_hit, movi;

  assign op_hi = i_word[31:16];
  assign op_lo = i_word[15:0];
  assign pc_hi = {ifetch.addr[31:2], 2'b00};
  assign t_hi = rcc_br_target(op_hi, pc_hi, cnd_en, unc_en);
  assign t_lo = rcc_br_target(op_lo, pc_hi + 32'h2, cnd_en, unc_en);
  assign movi = op_hi[15:12] == RCC_OP_MOVI && op_hi[3:0] == RCC_OP_MOVI;
  // only a value just loaded by an immediate move counts as known
  assign ind_hit = unc_en && kn_vld_r && op_hi[15:12] == RCC_OP_REGGRP &&
                   op_hi[11:8] == kn_reg_r &&
                   (op_hi[7:0] == RCC_OP_JMP || op_hi[7:0] == RCC_OP_JSR ||
                    op_hi[7:0] == RCC_OP_JSRN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kn_vld_r <= 1'b0;
      kn_reg_r <= '0;
      kn_val_r <= '0;
    end else if (i_deliv) begin
      kn_vld_r <= movi;
      kn_reg_r <= op_hi[11:8];
      kn_val_r <= {{12{op_hi[7]}}, op_hi[7:4], op_lo};
    end
  end

  // one pending slot: a newer prediction replaces an older one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pf_pend_r <= 1'b0;
      pf_addr_r <= '0;
    end else if (fl_i || !pc_en) begin
      pf_pend_r <= 1'b0;
    end else if (i_deliv) begin
      if (ind_hit) begin
        pf_pend_r <= 1'b1;
        pf_addr_r <= kn_val_r;
      end else if (t_hi[32]) begin
        pf_pend_r <= 1'b1;
        pf_addr_r <= t_hi[31:0];
      end else if (t_lo[32]) begin
        pf_pend_r <= 1'b1;
        pf_addr_r <= t_lo[31:0];
      end else if (seq_en) begin
        pf_pend_r <= 1'b1;
        pf_addr_r <= {ifetch.addr[31:4], 4'h0} + RCC_LINE_BYTES;
      end
    end else if (state_r == RCC_IDLE && !i_srv && pf_pend_r &&
                 !(d_srv && !(dc_en && d_hit))) begin
      pf_pend_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/rcc_rom_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rcc_rom_model
  import rcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ready,
  output rcc_pkg::rcc_line_t mem_line
);
  logic [2:0] wait_r;
  logic slow_r;
  rcc_line_t line;
  // contents use a[22:0] only, so aliases above bit 22 read alike
  function automatic logic [31:0] word(input logic [31:0] a);
    case ({a[22:2], 2'b00})
      23'h3000: word = {RCC_OP_BRA, 12'h100, 16'h0009};
      23'h4000: word = {RCC_OP_BT, 8'h40, 16'h0009};
      23'h6000: word = {RCC_OP_BSR, 12'h080, 16'h0009};
      // immediate move of 0x58000 into then a jump through
      23'h5000: word = {RCC_OP_MOVI, 4'h3, 4'h5, RCC_OP_MOVI, 16'h8000};
      23'h5004: word = {RCC_OP_REGGRP, 4'h3, RCC_OP_JMP, 16'h0009};
      default: word = ~{9'h000, a[22:2], 2'b00};
    endcase
  endfunction
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[32*i +: 32] = word({mem_addr[31:4], i[1:0], 2'b00});
    end
  end
  // released bus shows the inverse so stale data cannot pass as a fill
  assign mem_line = mem_ready ? line : ~line;
  // alternate prompt and slow answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 3'h0;
      slow_r <= 1'b0;
      mem_ready <= 1'b0;
    end else if (mem_ready) begin
      mem_ready <= 1'b0;
      slow_r <= !slow_r;
      wait_r <= 3'h0;
    end else if (mem_req) begin
      mem_ready <= (wait_r == (slow_r ? 3'h3 : 3'h0));
      wait_r <= wait_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/rcc_cache_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module rcc_cache_asserts
  import rcc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire rcc_pkg::rcc_rdreq_s dread,
  input wire logic dr_ack,
  input wire logic if_ack,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_req;
  assign rd_req = hsel && htrans[1] && hready && !hwrite;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  main_read_a: assert property (
    rd_req && haddr == RCC_MAIN_ADDR |=> hrdata[31:1] == 31'h0)
    else $error("main control read shows flush or reserved bits");
  pf_read_a: assert property (
    rd_req && haddr == RCC_PF_ADDR |=> (hrdata & ~RCC_PF_MASK) == 32'h0)
    else $error("prefetch control read shows reserved bits");
  unmapped_read_a: assert property (rd_req && haddr != RCC_MAIN_ADDR
    && haddr != RCC_PF_ADDR |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  fill_hold_a: assert property (
    mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
    else $error("fill request dropped or moved");
  fill_align_a: assert property (mem_req |-> mem_addr[3:0] == 4'h0)
    else $error("fill address not line aligned");
  fill_end_a: assert property (mem_req && mem_ready |=> !mem_req)
    else $error("fill request stays after done");
  data_ack_a: assert property (
    dr_ack |-> $past(dread.req) ##1 !dr_ack)
    else $error("data ack without request or too long");
  instr_ack_a: assert property (if_ack |=> !if_ack)
    else $error("instruction ack too long");
  cover property (mem_req && mem_ready);
  cover property (if_ack);
  cover property (dr_ack);
endmodule
bind rcc_cache rcc_cache_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .dread(dread), .dr_ack(dr_ack), .if_ack(if_ack), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_ready(mem_ready));
`default_nettype wire

// *** tb/rcc_cache_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module rcc_cache_test;
  import rcc_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [31:0] a;
    logic [31:0] d;
  } rcc_row_s;
  localparam logic [1:0] KD = 2'h0, KI = 2'h1, KW = 2'h2, KR = 2'h3;
  localparam logic [31:0] MR = RCC_MAIN_ADDR, PR = RCC_PF_ADDR;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, standby = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, if_data, dr_data, mem_addr;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, if_ack, dr_ack, mem_req, mem_ready;
  rcc_rdreq_s ifetch = '0, dread = '0;
  rcc_line_t mem_line;
  int mismatches = 0, cmp_count = 0, fills = 0;
  // data rows: d is the number of line fills a KD or KI access must cause, and the register value for KW or KR
  rcc_row_s rows [] = '{
    '{KR, MR, 32'h1}, '{KW, PR, 32'h000000F5}, '{KR, PR, 32'hF5},
    '{KW, MR, 32'h0000000F}, '{KR, MR, 32'h1}, '{KW, 32'hFFFC1404, 32'h1},
    '{KR, 32'hFFFC1404, 32'h0}, '{KD, 32'h1004, 32'h1},
    '{KD, 32'h100C, 32'h0}, '{KD, 32'h80001008, 32'h0},
    '{KD, 32'h1010, 32'h1}, '{KD, 32'h1020, 32'h1}, '{KD, 32'h1030, 32'h1},
    '{KD, 32'h1000, 32'h0}, '{KD, 32'h1040, 32'h1}, '{KD, 32'h1000, 32'h0},
    '{KD, 32'h1010, 32'h1}, '{KI, 32'h2000, 32'h1}, '{KI, 32'h2010, 32'h0},
    '{KI, 32'h3000, 32'h1}, '{KI, 32'h3200, 32'h0}, '{KI, 32'h4000, 32'h1},
    '{KI, 32'h4080, 32'h0}, '{KI, 32'h6000, 32'h1}, '{KI, 32'h6100, 32'h0},
    '{KW, MR, 32'h3}, '{KD, 32'h1000, 32'h1}, '{KI, 32'h2000, 32'h0},
    '{KW, MR, 32'h5}, '{KI, 32'h2000, 32'h1}, '{KD, 32'h1000, 32'h0},
    '{KI, 32'h5000, 32'h1}, '{KI, 32'h5004, 32'h0}, '{KI, 32'h58000, 32'h0},
    '{KW, MR, 32'h9}, '{KD, 32'h1000, 32'h1}, '{KW, PR, 32'hF4},
    '{KD, 32'h1000, 32'h1}, '{KD, 32'h1000, 32'h1}, '{KW, PR, 32'hF5},
    '{KD, 32'h1000, 32'h0}, '{KW, MR, 32'h0}, '{KD, 32'h1000, 32'h1},
    '{KW, MR, 32'h1}, '{KD, 32'h1000, 32'h0}, '{KW, PR, 32'hE5},
    '{KI, 32'h7000, 32'h1}, '{KI, 32'h7010, 32'h1}, '{KW, PR, 32'hD5},
    '{KI, 32'h8000, 32'h1}, '{KI, 32'h8010, 32'h1}, '{KW, PR, 32'hB5},
    '{KI, 32'h3000, 32'h1}, '{KI, 32'h3200, 32'h1}, '{KW, PR, 32'h75},
    '{KI, 32'h4000, 32'h1}, '{KI, 32'h4080, 32'h1}};
  always #25 hclk = ~hclk;
  rcc_cache uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .standby(standby), .ifetch(ifetch), .if_ack(if_ack),
    .if_data(if_data), .dread(dread), .dr_ack(dr_ack), .dr_data(dr_data),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ready(mem_ready),
    .mem_line(mem_line));
  rcc_rom_model mem (.clk(hclk), .rst_n(hresetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_line(mem_line));
  always @(posedge hclk) if (mem_req && mem_ready) fills <= fills + 1;
  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= RCC_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic run(input rcc_row_s r);
    logic [31:0] v;
    int f0, t;
    f0 = fills;
    t = 0;
    if (r.op == KD) dread <= '{1'b1, r.a};
    if (r.op == KI) ifetch <= '{1'b1, r.a};
    if (r.op[1]) begin
      bus(r.op[0] == 1'b0, r.a, r.d, v);
      if (r.op[0]) check("register", r.d, v);
    end else begin
      do begin
        @(negedge hclk);
        t++;
      end while ((r.op[0] ? if_ack : dr_ack) !== 1'b1 && t < 200);
      v = r.op[0] ? if_data : dr_data;
      @(posedge hclk);
      ifetch.req <= 1'b0;
      dread.req <= 1'b0;
      check("word", mem.word(r.a), v);
      check("fills", r.d, 32'(fills - f0));
      check("ack", 32'h1, 32'(t < 200));
      repeat (12) @(posedge hclk);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    run('{KR, PR, RCC_PF_RST});
    $display("reset values done");
    foreach (rows[i]) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    run('{KW, MR, 32'h0});
    run('{KW, PR, 32'h0});
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
    @(posedge hclk);
    run('{KR, MR, RCC_MAIN_RST});
    run('{KR, PR, RCC_PF_RST});
    run('{KD, 32'h1000, 32'h1});
    $display("standby done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    run('{KD, 32'h1000, 32'h1});
    $display("mid-run reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
